/* File: hdl/lfmc_pkg.sv */
// Purpose: Shared constants and types of the LED flash mode controller
// Assumes: 40 MHz system clock, 8-bit register port
// Notes:   Offsets are register addresses on the decoded register port
package lfmc_pkg;
   // Register addresses
   localparam logic [7:0] ADDR_TORCH_BR  = 8'ha0;
   localparam logic [7:0] ADDR_FLASH_BR  = 8'hb0;
   localparam logic [7:0] ADDR_MODE_EN   = 8'h10;
   localparam logic [7:0] ADDR_IND_CFG   = 8'h11;
   localparam logic [7:0] ADDR_FLAGS     = 8'hd0;
   localparam logic [7:0] ADDR_CFG1      = 8'he0;
   localparam logic [7:0] ADDR_CFG2      = 8'hf0;
   localparam logic [7:0] REG_RESET      = 8'h00;

   // Mode field encodings
   localparam logic [1:0] MODE_OFF       = 2'h0;
   localparam logic [1:0] MODE_PRIVACY   = 2'h1;
   localparam logic [1:0] MODE_TORCH     = 2'h2;
   localparam logic [1:0] MODE_FLASH     = 2'h3;

   // Field positions
   localparam int EN_PRIV_HIGH   = 2;  // mode_enable: privacy peak level
   localparam int EN_SRC_A       = 3;  // mode_enable: source a used
   localparam int EN_SRC_B       = 4;  // mode_enable: source b used
   localparam int EN_EDGE        = 5;  // mode_enable: edge trigger
   localparam int EN_MSG_IND     = 6;  // mode_enable: message indicator
   localparam int IC_TERM        = 3;  // indicator_config: stop after flash
   localparam int IC_SEL_A       = 4;
   localparam int IC_SEL_B       = 5;
   localparam int IC_BLINK_LO    = 6;
   localparam int C1_STROBE_EN   = 2;
   localparam int C1_NTC_EN      = 4;
   localparam int C2_NTC_OFF     = 1;  // 1: shutdown, 0: force torch
   localparam int C2_VM_OFF      = 2;
   localparam int C2_VM_EN       = 3;
   localparam int C2_VFM_EN      = 4;
   localparam int FL_TIMEOUT     = 0;
   localparam int FL_NTC         = 5;
   localparam int FL_VFM         = 6;
   localparam int FL_VM          = 7;

   // Current code space: torch codes 0..7, flash codes 8..23
   localparam logic [4:0] FLASH_BASE     = 5'h08;
   localparam logic [4:0] TORCH_LOW      = 5'h00;
   localparam logic [4:0] TORCH_HIGH     = 5'h07;
   localparam logic [1:0] BLINK_ALWAYS   = 2'h3;
   localparam logic [3:0] PWM_LAST_SLOT  = 4'h9;  // Ten slots, 10 % each

   // Timing
   localparam int CLK_KHZ        = 40000;
   localparam int STEP_US        = 32;
   localparam int STEP_CYC       = (STEP_US * CLK_KHZ + 999) / 1000;
   localparam int BLINK_BASE_MS  = 128;
   localparam int BLINK_BASE_CYC = BLINK_BASE_MS * CLK_KHZ;
   localparam int PWM_SLOT_US    = 10;
   localparam int PWM_SLOT_CYC   = PWM_SLOT_US * CLK_KHZ / 1000;
   localparam int TIMEOUT_MS     = 600;
   localparam int TIMEOUT_CYC    = TIMEOUT_MS * CLK_KHZ;

   typedef enum logic [1:0] {ST_IDLE, ST_PRECHG, ST_ACTIVE} lfmc_state_t;
endpackage : lfmc_pkg

/* File: hdl/lfmc_tick.sv */
// Purpose: Free divider that pulses once every DIV cycles while run is high
// Assumes: Synchronous active-high reset
// Notes:   Restarts from zero whenever run drops
module lfmc_tick #(
   parameter int DIV = 1280
) (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   input  wire logic run,
   output logic      tick
);
   initial
   begin
      if (DIV < 1)
         $error("lfmc_tick: DIV must be at least 1");
   end

   logic [31:0] cnt_reg;
   logic [31:0] cnt_next;
   logic        tick_next;

   // Count up, wrap on the last cycle
   always_comb
   begin
      cnt_next  = cnt_reg + 32'h1;
      tick_next = 1'b0;
      if (!run)
         cnt_next = 32'h0;
      else if (cnt_reg == 32'(DIV - 1))
      begin
         cnt_next  = 32'h0;
         tick_next = 1'b1;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         cnt_reg <= 32'h0;
         tick    <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         tick    <= tick_next;
      end
   end
endmodule // lfmc_tick

/* File: hdl/lfmc_ctrl.sv */
// Purpose: Mode, ramp, trigger, indicator and fault control of the driver
// Assumes: Register port already decoded from the serial link
// Notes:   Codes 0..7 are torch levels, 8..23 flash levels
// How it works
// R1: Thermistor trip while torch or flash active sets flags bit 5.
// R2: Thermistor fault forces torch or off until read and voltage recovers.
// R3: Supply flash monitor sets flags bit 6; ramp frozen until read.
// R4: Supply monitor sets bit 7; forced state ends after read and recovery.
// R5: Mode field 11 flash, 10 torch, 01 privacy, 00 off.
// R6: Enable bit 6 drives the message indicator, independent of mode.
// R7: Sources stay off during precharge until output reaches 2.2 V.
// R8: Sources step one code every 32 us up to the target.
// R9: Near supply, boost if headroom low, else pass with switching stopped.
// R10: Flash uses 16 codes per source from the flash brightness register.
// R11: Trigger pin rising starts flash when config 1 bit 2 is set.
// R12: Edge trigger: pin-started flash ends only on timeout.
// R13: Level trigger: flash ends on pin low, mode write 00 or timeout.
// R14: Level trigger: pin toggle during flash restarts the timeout.
// R15: Any flash end turns both sources fully off.
// R16: Mode field clears after flash; privacy resumes if stop bit low.
// R17: Torch offers 8 codes per source, ramped at 32 us per step.
// R18: Indicator config selects sources, stop-after-flash, blink and duty.
// R19: Privacy modulates lowest or highest torch level, per enable bit 2.
// R20: Duty code selects 10 % to 80 % in 10 % steps.
// R21: Blink code selects 128, 256, 512 ms half-period or always on.
// R22: Reading the flags register clears every latched flag.
// R23: Duty n gives (n+1)*10 %; blink 00/01/10 give 128/256/512 ms.
// R24: Mode writes re-enabling a faulted mode are refused until flags read.
module lfmc_ctrl #(
   parameter int BLINK_CYC   = lfmc_pkg::BLINK_BASE_CYC,
   parameter int TIMEOUT_CYC = lfmc_pkg::TIMEOUT_CYC,
   parameter int PWM_CYC     = lfmc_pkg::PWM_SLOT_CYC
) (
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       strobe_pin,
   input  wire logic       thermistor_sense_low,
   input  wire logic       thermistor_sense_ok,
   input  wire logic       vin_mon_low,
   input  wire logic       vin_flash_low,
   input  wire logic       vout_ready,
   input  wire logic       vout_near_vin,
   input  wire logic       headroom_low,
   output logic            current_source_a_en,
   output logic      [4:0] current_source_a_code,
   output logic            current_source_b_en,
   output logic      [4:0] current_source_b_code,
   output logic            precharge_on,
   output logic            boost_on,
   output logic            pass_transistor_on,
   output logic            thermistor_indicator_pin
);
   initial
   begin
      if (BLINK_CYC < 1 || TIMEOUT_CYC < 2 || PWM_CYC < 1)
         $error("lfmc_ctrl: timing parameters too small");
   end

   typedef struct packed {
      logic [7:0]           mode_en;
      logic [7:0]           ind_cfg;
      logic [7:0]           torch_br;
      logic [7:0]           flash_br;
      logic [7:0]           cfg1;
      logic [7:0]           cfg2;
      logic [7:0]           flags;
      logic [7:0]           rdata;
      lfmc_pkg::lfmc_state_t state;
      logic [4:0]           cur;
      logic                 flash_on;
      logic                 pin_trig;
      logic                 strobe_d;
      logic [31:0]          to_cnt;
      logic                 ntc_hold;
      logic                 vm_hold;
      logic [2:0]           blink_cnt;
      logic [3:0]           pwm_slot;
      logic                 a_en;
      logic [4:0]           a_code;
      logic                 b_en;
      logic [4:0]           b_code;
      logic                 prechg;
      logic                 boost;
      logic                 pass;
      logic                 ind;
   } lfmc_st_t;

   lfmc_st_t   st_reg;
   lfmc_st_t   st_next;
   logic       step_tick;
   logic       blink_tick;
   logic       pwm_tick;
   logic [1:0] eff_mode;
   logic [1:0] drv_mode;
   logic       set_ntc;
   logic       set_vfm;
   logic       set_vm;
   logic       set_to;
   logic       rd_flags;
   logic       rise;
   logic       flash_end;
   logic       blocked;
   logic [4:0] tgt_a;
   logic [4:0] tgt_b;
   logic [4:0] tgt_max;
   logic       priv_on;
   logic [4:0] priv_lvl;

   // Ramp step, blink base and PWM slot timebases
   lfmc_tick #(.DIV(lfmc_pkg::STEP_CYC)) u_step (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .run     (st_reg.state == lfmc_pkg::ST_ACTIVE),
      .tick    (step_tick)
   );
   lfmc_tick #(.DIV(BLINK_CYC)) u_blink (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .run     (1'b1),
      .tick    (blink_tick)
   );
   lfmc_tick #(.DIV(PWM_CYC)) u_pwm (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .run     (1'b1),
      .tick    (pwm_tick)
   );

   // Event and mode terms from the present state
   always_comb
   begin
      rd_flags = reg_rd && (reg_addr == lfmc_pkg::ADDR_FLAGS);   // R22
      rise     = strobe_pin && !st_reg.strobe_d;
      blocked  = st_reg.flags[lfmc_pkg::FL_NTC]
                 || st_reg.flags[lfmc_pkg::FL_VM];                // R24
      if (st_reg.flash_on)
         eff_mode = lfmc_pkg::MODE_FLASH;
      else if (st_reg.mode_en[1:0] == lfmc_pkg::MODE_FLASH)
         eff_mode = lfmc_pkg::MODE_OFF;
      else
         eff_mode = st_reg.mode_en[1:0];                          // R5
      // Fault forcing: shutdown or fall back to torch
      drv_mode = eff_mode;
      if ((st_reg.ntc_hold && st_reg.cfg2[lfmc_pkg::C2_NTC_OFF])
          || (st_reg.vm_hold && st_reg.cfg2[lfmc_pkg::C2_VM_OFF]))
         drv_mode = lfmc_pkg::MODE_OFF;                           // R2 R4
      else if ((st_reg.ntc_hold || st_reg.vm_hold)
               && eff_mode == lfmc_pkg::MODE_FLASH)
         drv_mode = lfmc_pkg::MODE_TORCH;                         // R2 R4
      set_ntc = (st_reg.state == lfmc_pkg::ST_ACTIVE)
                && eff_mode[1] && st_reg.cfg1[lfmc_pkg::C1_NTC_EN]
                && thermistor_sense_low;                          // R1
      set_vfm = st_reg.flash_on && st_reg.cfg2[lfmc_pkg::C2_VFM_EN]
                && vin_flash_low;                                 // R3
      set_vm  = st_reg.cfg2[lfmc_pkg::C2_VM_EN] && vin_mon_low;   // R4
      set_to  = st_reg.flash_on
                && (st_reg.to_cnt == 32'(TIMEOUT_CYC - 1));
      // Flash termination conditions
      flash_end = st_reg.flash_on
         && (set_to                                               // R12
             || (st_reg.pin_trig && !st_reg.mode_en[lfmc_pkg::EN_EDGE]
                 && !strobe_pin)                                  // R13
             || (reg_wr && reg_addr == lfmc_pkg::ADDR_MODE_EN
                 && reg_wdata[1:0] == lfmc_pkg::MODE_OFF
                 && !(st_reg.pin_trig
                      && st_reg.mode_en[lfmc_pkg::EN_EDGE])));     // R13
      // Per-source targets
      if (drv_mode == lfmc_pkg::MODE_FLASH)
      begin
         tgt_a = lfmc_pkg::FLASH_BASE + {1'b0, st_reg.flash_br[3:0]}; // R10
         tgt_b = lfmc_pkg::FLASH_BASE + {1'b0, st_reg.flash_br[7:4]};
      end
      else
      begin
         tgt_a = {2'b00, st_reg.torch_br[2:0]};                   // R17
         tgt_b = {2'b00, st_reg.torch_br[5:3]};
      end
      tgt_max = (tgt_a > tgt_b) ? tgt_a : tgt_b;
      // Privacy modulation
      priv_lvl = st_reg.mode_en[lfmc_pkg::EN_PRIV_HIGH]
                 ? lfmc_pkg::TORCH_HIGH : lfmc_pkg::TORCH_LOW;    // R19
      priv_on  = (st_reg.pwm_slot <= {1'b0, st_reg.ind_cfg[2:0]}) // R20 R23
                 && ((st_reg.ind_cfg[7:6] == lfmc_pkg::BLINK_ALWAYS)
                     || !st_reg.blink_cnt[st_reg.ind_cfg[7:6]]);  // R21 R23
   end

   // Next state
   always_comb
   begin
      st_next          = st_reg;
      st_next.strobe_d = strobe_pin;
      st_next.rdata    = 8'h00;
      // Register writes
      if (reg_wr)
      begin
         if (reg_addr == lfmc_pkg::ADDR_TORCH_BR)
            st_next.torch_br = reg_wdata;
         else if (reg_addr == lfmc_pkg::ADDR_FLASH_BR)
            st_next.flash_br = reg_wdata;
         else if (reg_addr == lfmc_pkg::ADDR_IND_CFG)
            st_next.ind_cfg = reg_wdata;                          // R18
         else if (reg_addr == lfmc_pkg::ADDR_CFG1)
            st_next.cfg1 = reg_wdata;
         else if (reg_addr == lfmc_pkg::ADDR_CFG2)
            st_next.cfg2 = reg_wdata;
         else if (reg_addr == lfmc_pkg::ADDR_MODE_EN)
         begin
            st_next.mode_en[7:2] = reg_wdata[7:2];
            if (!(blocked && reg_wdata[1:0] != lfmc_pkg::MODE_OFF))
               st_next.mode_en[1:0] = reg_wdata[1:0];             // R24
            if (!blocked && !st_reg.flash_on
                && reg_wdata[1:0] == lfmc_pkg::MODE_FLASH)
            begin
               st_next.flash_on = 1'b1;
               st_next.pin_trig = 1'b0;
               st_next.to_cnt   = 32'h0;
            end
         end
      end
      // Register reads, unmapped addresses read zero
      if (reg_rd)
      begin
         if (reg_addr == lfmc_pkg::ADDR_TORCH_BR)
            st_next.rdata = st_reg.torch_br;
         else if (reg_addr == lfmc_pkg::ADDR_FLASH_BR)
            st_next.rdata = st_reg.flash_br;
         else if (reg_addr == lfmc_pkg::ADDR_MODE_EN)
            st_next.rdata = st_reg.mode_en;
         else if (reg_addr == lfmc_pkg::ADDR_IND_CFG)
            st_next.rdata = st_reg.ind_cfg;
         else if (reg_addr == lfmc_pkg::ADDR_CFG1)
            st_next.rdata = st_reg.cfg1;
         else if (reg_addr == lfmc_pkg::ADDR_CFG2)
            st_next.rdata = st_reg.cfg2;
         else if (reg_addr == lfmc_pkg::ADDR_FLAGS)
            st_next.rdata = st_reg.flags;
      end
      // Flags: a read clears, a same-cycle event still sets
      st_next.flags = (rd_flags ? 8'h00 : st_reg.flags)
         | {set_vm, set_vfm, set_ntc, 4'h0, set_to};              // R22
      if (set_ntc)
         st_next.ntc_hold = 1'b1;                                 // R1
      else if (!st_reg.flags[lfmc_pkg::FL_NTC] && thermistor_sense_ok)
         st_next.ntc_hold = 1'b0;                                 // R2
      if (set_vm)
         st_next.vm_hold = 1'b1;
      else if (!st_reg.flags[lfmc_pkg::FL_VM] && !vin_mon_low)
         st_next.vm_hold = 1'b0;                                  // R4
      // Hardware trigger start and timeout restart
      if (!st_reg.flash_on && !blocked && rise
          && st_reg.cfg1[lfmc_pkg::C1_STROBE_EN])
      begin
         st_next.flash_on = 1'b1;                                 // R11
         st_next.pin_trig = 1'b1;
         st_next.to_cnt   = 32'h0;
      end
      else if (st_reg.flash_on)
      begin
         st_next.to_cnt = st_reg.to_cnt + 32'h1;
         if (!st_reg.mode_en[lfmc_pkg::EN_EDGE]
             && strobe_pin != st_reg.strobe_d)
            st_next.to_cnt = 32'h0;                               // R14
      end
      // Flash end: sources off, mode field back to off or privacy
      if (flash_end)
      begin
         st_next.flash_on     = 1'b0;
         st_next.pin_trig     = 1'b0;
         st_next.state        = lfmc_pkg::ST_IDLE;                // R15
         st_next.mode_en[1:0] = st_reg.ind_cfg[lfmc_pkg::IC_TERM]
            ? lfmc_pkg::MODE_OFF : lfmc_pkg::MODE_PRIVACY;        // R16
      end
      else
      begin
         case (st_reg.state)
            lfmc_pkg::ST_IDLE:
            begin
               st_next.cur = 5'h00;
               if (drv_mode != lfmc_pkg::MODE_OFF)
                  st_next.state = lfmc_pkg::ST_PRECHG;
            end
            lfmc_pkg::ST_PRECHG:
            begin
               if (drv_mode == lfmc_pkg::MODE_OFF)
                  st_next.state = lfmc_pkg::ST_IDLE;
               else if (vout_ready)
                  st_next.state = lfmc_pkg::ST_ACTIVE;            // R7
            end
            lfmc_pkg::ST_ACTIVE:
            begin
               if (drv_mode == lfmc_pkg::MODE_OFF)
                  st_next.state = lfmc_pkg::ST_IDLE;
               else if (step_tick && st_reg.cur < tgt_max
                        && !st_reg.flags[lfmc_pkg::FL_VFM])
                  st_next.cur = st_reg.cur + 5'h01;               // R8 R3
            end
            default:
               st_next.state = lfmc_pkg::ST_IDLE;
         endcase
      end
      // Indicator timebases
      if (blink_tick)
         st_next.blink_cnt = st_reg.blink_cnt + 3'h1;
      if (pwm_tick)
         st_next.pwm_slot = (st_reg.pwm_slot == lfmc_pkg::PWM_LAST_SLOT)
                            ? 4'h0 : st_reg.pwm_slot + 4'h1;
      // Registered drive outputs
      st_next.a_en   = 1'b0;
      st_next.b_en   = 1'b0;
      st_next.a_code = 5'h00;
      st_next.b_code = 5'h00;
      if (st_reg.state == lfmc_pkg::ST_ACTIVE && !flash_end)
      begin
         if (drv_mode == lfmc_pkg::MODE_PRIVACY)
         begin
            st_next.a_en   = priv_on && st_reg.ind_cfg[lfmc_pkg::IC_SEL_A];
            st_next.b_en   = priv_on && st_reg.ind_cfg[lfmc_pkg::IC_SEL_B];
            st_next.a_code = priv_lvl;
            st_next.b_code = priv_lvl;
         end
         else if (drv_mode != lfmc_pkg::MODE_OFF)
         begin
            st_next.a_en   = st_reg.mode_en[lfmc_pkg::EN_SRC_A];
            st_next.b_en   = st_reg.mode_en[lfmc_pkg::EN_SRC_B];
            st_next.a_code = (st_reg.cur < tgt_a) ? st_reg.cur : tgt_a;
            st_next.b_code = (st_reg.cur < tgt_b) ? st_reg.cur : tgt_b;
         end
      end
      st_next.prechg = (st_reg.state == lfmc_pkg::ST_PRECHG);
      st_next.boost  = (st_reg.state == lfmc_pkg::ST_ACTIVE)
                       && vout_near_vin && headroom_low;          // R9
      st_next.pass   = (st_reg.state == lfmc_pkg::ST_ACTIVE)
                       && vout_near_vin && !headroom_low;         // R9
      st_next.ind    = st_reg.mode_en[lfmc_pkg::EN_MSG_IND];      // R6
   end

   // State register
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         st_reg         <= '0;
         st_reg.state   <= lfmc_pkg::ST_IDLE;
         st_reg.mode_en <= lfmc_pkg::REG_RESET;
      end
      else
         st_reg <= st_next;
   end

   assign reg_rdata                = st_reg.rdata;
   assign current_source_a_en      = st_reg.a_en;
   assign current_source_a_code    = st_reg.a_code;
   assign current_source_b_en      = st_reg.b_en;
   assign current_source_b_code    = st_reg.b_code;
   assign precharge_on             = st_reg.prechg;
   assign boost_on                 = st_reg.boost;
   assign pass_transistor_on       = st_reg.pass;
   assign thermistor_indicator_pin = st_reg.ind;

   // Checks on the driven behaviour
   a_ntc_flag_set: assert property (@(posedge sys_clk) disable iff (sys_rst) // R1
      set_ntc |=> st_reg.flags[lfmc_pkg::FL_NTC] && st_reg.ntc_hold)
      else $error("thermistor trip not latched");
   a_vm_hold_keep: assert property (@(posedge sys_clk) disable iff (sys_rst) // R4
      st_reg.vm_hold && st_reg.flags[lfmc_pkg::FL_VM] |=> st_reg.vm_hold)
      else $error("supply fault released before flags read");
   a_vfm_ramp_frz: assert property (@(posedge sys_clk) disable iff (sys_rst) // R3
      st_reg.flags[lfmc_pkg::FL_VFM] && st_reg.state == lfmc_pkg::ST_ACTIVE
      && !flash_end |=> st_reg.cur <= $past(st_reg.cur))
      else $error("ramp advanced under supply flash fault");
   a_prechg_off: assert property (@(posedge sys_clk) disable iff (sys_rst) // R7
      st_reg.state == lfmc_pkg::ST_PRECHG |=> !st_reg.a_en && !st_reg.b_en)
      else $error("source on during precharge");
   a_ramp_one_step: assert property (@(posedge sys_clk) disable iff (sys_rst) // R8
      st_reg.state == lfmc_pkg::ST_ACTIVE && !step_tick
      |=> st_reg.cur == $past(st_reg.cur) || st_reg.state != lfmc_pkg::ST_ACTIVE)
      else $error("ramp stepped without step tick");
   a_flash_end_off: assert property (@(posedge sys_clk) disable iff (sys_rst) // R15
      flash_end |=> !st_reg.a_en && !st_reg.b_en && !st_reg.flash_on)
      else $error("sources not off after flash");
   a_mode_clear: assert property (@(posedge sys_clk) disable iff (sys_rst) // R16
      flash_end && st_reg.ind_cfg[lfmc_pkg::IC_TERM]
      |=> st_reg.mode_en[1:0] == lfmc_pkg::MODE_OFF)
      else $error("mode field not cleared after flash");
   a_to_restart: assert property (@(posedge sys_clk) disable iff (sys_rst) // R14
      st_reg.flash_on && !st_reg.mode_en[lfmc_pkg::EN_EDGE]
      && strobe_pin != st_reg.strobe_d && !flash_end |=> st_reg.to_cnt == 32'h0)
      else $error("timeout not restarted on toggle");
   a_edge_hold: assert property (@(posedge sys_clk) disable iff (sys_rst) // R12
      st_reg.flash_on && st_reg.pin_trig && st_reg.mode_en[lfmc_pkg::EN_EDGE]
      && !set_to |=> st_reg.flash_on)
      else $error("edge-triggered flash ended before timeout");
   a_flags_clear: assert property (@(posedge sys_clk) disable iff (sys_rst) // R22
      rd_flags && !set_to && !set_ntc && !set_vfm && !set_vm
      |=> st_reg.flags == 8'h00 && st_reg.rdata == $past(st_reg.flags))
      else $error("flags read did not clear");
   a_msg_ind: assert property (@(posedge sys_clk) disable iff (sys_rst) // R6
      ##1 thermistor_indicator_pin == $past(st_reg.mode_en[lfmc_pkg::EN_MSG_IND]))
      else $error("message indicator mismatch");
endmodule // lfmc_ctrl

/* File: bench/lfmc_analog_model.sv */
// Purpose: Output capacitor and LED headroom model of the far side
// Assumes: Precharge request and source enables from the controller
// Notes:   Cap reaches 2.2 V after three precharge cycles
module lfmc_analog_model (
   input  wire logic sys_clk,
   input  wire logic precharge_on,
   input  wire logic src_on,
   input  wire logic load_heavy,
   output logic      vout_ready,
   output logic      vout_near_vin,
   output logic      headroom_low
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] chg_reg = 2'h0;
   // Cap drains once the converter stops, so each start precharges
   always_ff @(posedge sys_clk)
   begin
      if (!(precharge_on || src_on)) chg_reg <= 2'h0;
      else if (chg_reg != 2'h3) chg_reg <= chg_reg + 2'h1;
   end
   assign vout_ready    = (chg_reg == 2'h3);
   assign vout_near_vin = vout_ready;
   assign headroom_low  = load_heavy;
endmodule // lfmc_analog_model

/* File: bench/tb.sv */
// Purpose: Self-checking bench of the flash mode controller
// Assumes: Short timeout parameter, ramp step of 1280 cycles
// Notes:   Torch codes and load drawn from an LFSR seeded with 11
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic       sys_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
   logic [7:0] seed = 8'h0b;
   logic       strobe_pin = 0, thermistor_sense_low = 0, load_heavy = 0;
   logic       thermistor_sense_ok = 0, vin_mon_low = 0, vin_flash_low = 0;
   logic       vout_ready, vout_near_vin, headroom_low, precharge_on;
   logic       current_source_a_en, current_source_b_en;
   logic [4:0] current_source_a_code, current_source_b_code;
   logic       boost_on, pass_transistor_on, thermistor_indicator_pin;
   int         fails = 0, checks_done = 0, on_cnt = 0;
   lfmc_ctrl #(.TIMEOUT_CYC(12000), .BLINK_CYC(64), .PWM_CYC(4)) lfmc_ctrl_i (
      .sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .strobe_pin, .thermistor_sense_low, .thermistor_sense_ok,
      .vin_mon_low, .vin_flash_low, .vout_ready, .vout_near_vin,
      .headroom_low, .current_source_a_en, .current_source_a_code,
      .current_source_b_en, .current_source_b_code, .precharge_on,
      .boost_on, .pass_transistor_on, .thermistor_indicator_pin);
   lfmc_analog_model lfmc_analog_model_i (.sys_clk, .precharge_on,
      .src_on(current_source_a_en | current_source_b_en), .load_heavy,
      .vout_ready, .vout_near_vin, .headroom_low);
   initial
   begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic chk(input string n, input logic [7:0] e, g);
      checks_done++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // One-cycle strobe; a new access waits an edge
   task automatic acc(input logic w, input logic [7:0] a, wd);
      @(posedge sys_clk);
      #1 {reg_addr, reg_wdata, reg_wr, reg_rd} = {a, wd, w, !w};
      @(posedge sys_clk);
      #1 {reg_wr, reg_rd} = 2'b00;
      d = reg_rdata;
   endtask
   // Ramp watch; a hang counts as a mismatch
   task automatic wait_code(input logic [4:0] c);
      logic [4:0] prev;
      prev = 5'h1f;
      for (int n = 0; n < 40000; n++)
      begin
         @(posedge sys_clk);
         #1;
         if (precharge_on === 1'b1) chk("pre_off", 0, current_source_a_en);
         if (current_source_a_en === 1'b1 && current_source_a_code !== prev)
         begin
            chk("step", 5'(prev + 5'h1), current_source_a_code);
            prev = current_source_a_code;
         end
         if (current_source_a_en === 1'b1 && prev === c) return;
      end
      fails++;
      test_done();
   endtask
   task automatic wait_en(input logic v, input int lim);
      for (int n = 0; n < lim; n++)
      begin
         @(posedge sys_clk);
         #1;
         if (current_source_a_en === v) return;
      end
      fails++;
      test_done();
   endtask
   // Main sequence
   initial
   begin
      repeat (5) @(posedge sys_clk);
      #1 sys_rst = 0;
      acc(0, lfmc_pkg::ADDR_MODE_EN, 0);
      chk("mode_rst", 0, d);
      acc(0, 8'h55, 0);
      chk("unmapped", 0, d);
      seed = lfsr(seed);
      load_heavy = seed[7];
      acc(1, lfmc_pkg::ADDR_TORCH_BR, seed);
      acc(0, lfmc_pkg::ADDR_TORCH_BR, 0);
      chk("torch_br", seed, d);
      acc(1, lfmc_pkg::ADDR_MODE_EN, 8'h4a);
      wait_code({2'h0, seed[2:0]});
      chk("msg_ind", 1, thermistor_indicator_pin);
      chk("boost", seed[7], boost_on);
      chk("pass", !seed[7], pass_transistor_on);
      acc(1, lfmc_pkg::ADDR_MODE_EN, 0);
      wait_en(0, 10);
      $display("test torch done");
      acc(1, lfmc_pkg::ADDR_CFG1, 8'h04);
      acc(1, lfmc_pkg::ADDR_IND_CFG, 8'h08);
      acc(1, lfmc_pkg::ADDR_FLASH_BR, 0);
      acc(1, lfmc_pkg::ADDR_MODE_EN, 8'h08);
      strobe_pin = 1;
      wait_code(5'h08);
      strobe_pin = 0;
      wait_en(0, 4);
      acc(0, lfmc_pkg::ADDR_MODE_EN, 0);
      chk("mode_clr", 8'h08, d);
      acc(1, lfmc_pkg::ADDR_MODE_EN, 8'h0b);
      wait_en(1, 40);
      strobe_pin = 1;
      @(posedge sys_clk);
      #1 strobe_pin = 0;
      repeat (11996) @(posedge sys_clk);
      #1 chk("restart", 1, current_source_a_en);
      $display("test level flash done");
      acc(1, lfmc_pkg::ADDR_MODE_EN, 8'h28);
      strobe_pin = 1;
      wait_en(1, 40);
      strobe_pin = 0;
      repeat (50) @(posedge sys_clk);
      #1 chk("edge_hold", 1, current_source_a_en);
      wait_en(0, 12000);
      acc(0, lfmc_pkg::ADDR_FLAGS, 0);
      chk("timeout", 8'h01, d & 8'h01);
      acc(0, lfmc_pkg::ADDR_FLAGS, 0);
      chk("flags_clr", 0, d);
      $display("test edge flash done");
      acc(1, lfmc_pkg::ADDR_CFG1, 8'h10);
      acc(1, lfmc_pkg::ADDR_CFG2, 8'h02);
      acc(1, lfmc_pkg::ADDR_MODE_EN, 8'h0a);
      wait_en(1, 40);
      thermistor_sense_low = 1;
      wait_en(0, 10);
      thermistor_sense_low = 0;
      acc(1, lfmc_pkg::ADDR_MODE_EN, 8'h08);
      acc(1, lfmc_pkg::ADDR_MODE_EN, 8'h0a);
      repeat (40) @(posedge sys_clk);
      #1 chk("held_off", 0, current_source_a_en);
      acc(0, lfmc_pkg::ADDR_MODE_EN, 0);
      chk("refused", 8'h08, d);
      acc(0, lfmc_pkg::ADDR_FLAGS, 0);
      chk("ntc_flag", 8'h20, d & 8'h20);
      thermistor_sense_ok = 1;
      acc(1, lfmc_pkg::ADDR_MODE_EN, 8'h0a);
      wait_en(1, 40);
      acc(1, lfmc_pkg::ADDR_IND_CFG, 8'hd7);
      acc(1, lfmc_pkg::ADDR_MODE_EN, 8'h05);
      repeat (40)
      begin
         @(posedge sys_clk);
         #1 on_cnt += current_source_a_en;
      end
      chk("duty", 8'h20, on_cnt);
      chk("priv_lvl", 8'h07, current_source_a_code);
      $display("test thermistor privacy done");
      test_done();
   end
endmodule // tb
